/* rtl/opse_ctrl.sv */
// Purpose: Output path enable and left speaker mixer control bank
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Unmapped reads return zero; unmapped writes are ignored
`timescale 1ns/1ps
`default_nettype none
`include "opse_cfg.svh"

module opse_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [`OPSE_ADDR_W-1:0] addr_i,
  input wire logic [`OPSE_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`OPSE_DATA_W-1:0] rdata_o,
  output opse_pkg::opse_enables_t enables_o,
  output opse_pkg::opse_left_mix_t left_mix_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  localparam logic [`OPSE_ADDR_W-1:0] OFS [`OPSE_NREG] = '{
    `OPSE_OFS_GAIN_EN, `OPSE_OFS_SPK_DRV, `OPSE_OFS_HP_STAGE, `OPSE_OFS_MIX_EN,
    `OPSE_OFS_LMIX_ROUTE, `OPSE_OFS_LMIX_LEVEL, `OPSE_OFS_LMIX_DAC};
  localparam logic [15:0] MASK [`OPSE_NREG] = '{
    `OPSE_MASK_GAIN_EN, `OPSE_MASK_SPK_DRV, `OPSE_MASK_HP_STAGE, `OPSE_MASK_MIX_EN,
    `OPSE_MASK_LMIX_ROUTE, `OPSE_MASK_LMIX_LEVEL, `OPSE_MASK_LMIX_DAC};
  localparam logic [15:0] RSTV [`OPSE_NREG] = '{
    `OPSE_RST_ZERO, `OPSE_RST_ZERO, `OPSE_RST_ZERO, `OPSE_RST_ZERO,
    `OPSE_RST_ZERO, `OPSE_RST_LMIX_LEVEL, `OPSE_RST_ZERO};

  // One-hot select of a register index, used for writes and reads
  function automatic logic [`OPSE_NREG-1:0] opse_decode(
    input logic [`OPSE_ADDR_W-1:0] a
  );
    logic [`OPSE_NREG-1:0] hit;
    hit = '0;
    for (int k = 0; k < `OPSE_NREG; k++) begin
      hit[k] = (a == OFS[k]);
    end
    return hit;
  endfunction : opse_decode

  wire logic [`OPSE_NREG-1:0] sel = opse_decode(addr_i);
  logic [15:0] q [`OPSE_NREG];

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  genvar g;
  generate
    for (g = 0; g < `OPSE_NREG; g++) begin : g_reg
      opse_reg #(
        .MASK(MASK[g]),
        .RST(RSTV[g])
      ) u_reg (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_i & sel[g]),
        .wdata_i(wdata_i),
        .q_o(q[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [15:0] rmux;
  always_comb begin
    rmux = '0;
    for (int k = 0; k < `OPSE_NREG; k++) begin
      if (sel[k]) begin
        rmux = rmux | q[k];
      end
    end
  end

  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  // Data only in the cycle after the strobe, zero otherwise
  assign rdata_next = rd_i ? rmux : '0;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, straight from stored bits

  wire logic [15:0] r_gain = q[0];
  wire logic [15:0] r_drv = q[1];
  wire logic [15:0] r_hp = q[2];
  wire logic [15:0] r_mix = q[3];
  wire logic [15:0] r_route = q[4];
  wire logic [15:0] r_level = q[5];
  wire logic [15:0] r_dac = q[6];

  assign enables_o.hp_left_gain_en = r_gain[`OPSE_B_HP_L_GAIN];
  assign enables_o.hp_right_gain_en = r_gain[`OPSE_B_HP_R_GAIN];
  assign enables_o.spk_left_gain_en = r_gain[`OPSE_B_SPK_L_GAIN];
  assign enables_o.spk_right_gain_en = r_gain[`OPSE_B_SPK_R_GAIN];
  assign enables_o.spk_left_driver_en = r_drv[`OPSE_B_SPK_L_DRV];
  assign enables_o.spk_right_driver_en = r_drv[`OPSE_B_SPK_R_DRV];
  assign enables_o.hp_left_input_stage_en = r_hp[`OPSE_B_HP_L_STAGE];
  assign enables_o.hp_right_input_stage_en = r_hp[`OPSE_B_HP_R_STAGE];
  assign enables_o.hp_left_mixer_en = r_mix[`OPSE_B_HP_L_MIX];
  assign enables_o.hp_right_mixer_en = r_mix[`OPSE_B_HP_R_MIX];
  assign enables_o.spk_left_mixer_en = r_mix[`OPSE_B_SPK_L_MIX];
  assign enables_o.spk_right_mixer_en = r_mix[`OPSE_B_SPK_R_MIX];

  assign left_mix_o.left_gain_source_select = r_route[`OPSE_B_SRC_SEL];
  assign left_mix_o.dac_left_to_left_mix = r_route[`OPSE_B_DAC_L];
  assign left_mix_o.dac_right_to_left_mix = r_route[`OPSE_B_DAC_R];
  assign left_mix_o.inmix_left_to_left_mix = r_route[`OPSE_B_INMIX_L];
  assign left_mix_o.inmix_right_to_left_mix = r_route[`OPSE_B_INMIX_R];
  assign left_mix_o.line_left_to_left_mix = r_route[`OPSE_B_LINE_L];
  assign left_mix_o.line_right_to_left_mix = r_route[`OPSE_B_LINE_R];
  assign left_mix_o.left_mix_mute = r_level[`OPSE_B_MUTE];
  assign left_mix_o.inmix_left_path_atten = r_level[`OPSE_B_INMIX_L_ATT];
  assign left_mix_o.inmix_right_path_atten = r_level[`OPSE_B_INMIX_R_ATT];
  assign left_mix_o.line_left_path_gain = r_level[`OPSE_B_LINE_L_HI:`OPSE_B_LINE_L_LO];
  assign left_mix_o.line_right_path_gain = r_level[`OPSE_B_LINE_R_HI:`OPSE_B_LINE_R_LO];
  assign left_mix_o.dac_left_path_atten = r_dac[`OPSE_B_DAC_L_ATT];
  assign left_mix_o.dac_right_path_atten = r_dac[`OPSE_B_DAC_R_ATT];

endmodule : opse_ctrl

`default_nettype wire

/* rtl/opse_cfg.svh */
// Purpose: Constants for the output path enable and speaker mix control bank
// Assumes: Register indices as printed; 16-bit register data
// Notes: Definitions only
`ifndef OPSE_CFG_SVH
`define OPSE_CFG_SVH

`define OPSE_ADDR_W 8
`define OPSE_DATA_W 16

`define OPSE_OFS_GAIN_EN 8'h1A
`define OPSE_OFS_SPK_DRV 8'h31
`define OPSE_OFS_HP_STAGE 8'h45
`define OPSE_OFS_MIX_EN 8'h63
`define OPSE_OFS_LMIX_ROUTE 8'h69
`define OPSE_OFS_LMIX_LEVEL 8'h6B
`define OPSE_OFS_LMIX_DAC 8'h6D

// Writable bit masks per register
`define OPSE_MASK_GAIN_EN 16'h0078
`define OPSE_MASK_SPK_DRV 16'h00C0
`define OPSE_MASK_HP_STAGE 16'h0011
`define OPSE_MASK_MIX_EN 16'h000F
`define OPSE_MASK_LMIX_ROUTE 16'h00BF
`define OPSE_MASK_LMIX_LEVEL 16'h01FF
`define OPSE_MASK_LMIX_DAC 16'h00C0

// Reset values
`define OPSE_RST_ZERO 16'h0000
`define OPSE_RST_LMIX_LEVEL 16'h013F

// Field positions
`define OPSE_B_HP_L_GAIN 6
`define OPSE_B_HP_R_GAIN 5
`define OPSE_B_SPK_L_GAIN 4
`define OPSE_B_SPK_R_GAIN 3
`define OPSE_B_SPK_R_DRV 7
`define OPSE_B_SPK_L_DRV 6
`define OPSE_B_HP_L_STAGE 4
`define OPSE_B_HP_R_STAGE 0
`define OPSE_B_HP_L_MIX 3
`define OPSE_B_HP_R_MIX 2
`define OPSE_B_SPK_L_MIX 1
`define OPSE_B_SPK_R_MIX 0
`define OPSE_B_SRC_SEL 7
`define OPSE_B_DAC_L 5
`define OPSE_B_DAC_R 4
`define OPSE_B_INMIX_L 3
`define OPSE_B_INMIX_R 2
`define OPSE_B_LINE_L 1
`define OPSE_B_LINE_R 0
`define OPSE_B_MUTE 8
`define OPSE_B_INMIX_L_ATT 7
`define OPSE_B_INMIX_R_ATT 6
`define OPSE_B_LINE_L_HI 5
`define OPSE_B_LINE_L_LO 3
`define OPSE_B_LINE_R_HI 2
`define OPSE_B_LINE_R_LO 0
`define OPSE_B_DAC_L_ATT 7
`define OPSE_B_DAC_R_ATT 6

`define OPSE_NREG 7

`endif

/* rtl/opse_pkg.sv */
// Purpose: Types for the output path enable and speaker mix control bank
// Assumes: Constants live in opse_cfg.svh
// Notes: Carrier structs for the control outputs
`default_nettype none

package opse_pkg;

  // Path enables
  typedef struct packed {
    logic hp_left_gain_en;
    logic hp_right_gain_en;
    logic spk_left_gain_en;
    logic spk_right_gain_en;
    logic spk_left_driver_en;
    logic spk_right_driver_en;
    logic hp_left_input_stage_en;
    logic hp_right_input_stage_en;
    logic hp_left_mixer_en;
    logic hp_right_mixer_en;
    logic spk_left_mixer_en;
    logic spk_right_mixer_en;
  } opse_enables_t;

  // Left speaker mixer routing and levels
  typedef struct packed {
    logic left_gain_source_select;
    logic dac_left_to_left_mix;
    logic dac_right_to_left_mix;
    logic inmix_left_to_left_mix;
    logic inmix_right_to_left_mix;
    logic line_left_to_left_mix;
    logic line_right_to_left_mix;
    logic left_mix_mute;
    logic inmix_left_path_atten;
    logic inmix_right_path_atten;
    logic [2:0] line_left_path_gain;
    logic [2:0] line_right_path_gain;
    logic dac_left_path_atten;
    logic dac_right_path_atten;
  } opse_left_mix_t;

endpackage : opse_pkg

`default_nettype wire

/* rtl/opse_reg.sv */
// Purpose: One masked control register with read back
// Assumes: Synchronous active-low reset
// Notes: Unwritable bits hold zero
`timescale 1ns/1ps
`default_nettype none

module opse_reg #(
  parameter logic [15:0] MASK = 16'h0000,
  parameter logic [15:0] RST = 16'h0000
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] q_o
);

  logic [15:0] val_reg;
  logic [15:0] val_next;

  assign val_next = wr_i ? (wdata_i & MASK) : val_reg;
  assign q_o = val_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      val_reg <= RST & MASK;
    end else begin
      val_reg <= val_next;
    end
  end

endmodule : opse_reg

`default_nettype wire

/* bench/opse_ctrl_sva.sv */
// Purpose: Port checks for the output path control bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to opse_ctrl below
`timescale 1ns/1ps
`default_nettype none
module opse_ctrl_sva (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire opse_pkg::opse_enables_t enables_o,
  input wire opse_pkg::opse_left_mix_t left_mix_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_gain; wr_i && addr_i == 8'h1a |=> enables_o[11:8] == $past(wdata_i[6:3]); endproperty
  a_gain: assert property (p_gain) else $error("gain enables wrong");
  property p_drv; wr_i && addr_i == 8'h31 |=> enables_o[7:6] == {$past(wdata_i[6]), $past(wdata_i[7])}; endproperty
  a_drv: assert property (p_drv) else $error("driver enables wrong");
  property p_stg; wr_i && addr_i == 8'h45 |=> enables_o[5:4] == {$past(wdata_i[4]), $past(wdata_i[0])}; endproperty
  a_stg: assert property (p_stg) else $error("input stage enables wrong");
  property p_mix; wr_i && addr_i == 8'h63 |=> enables_o[3:0] == $past(wdata_i[3:0]); endproperty
  a_mix: assert property (p_mix) else $error("mixer enables wrong");
  property p_rte; wr_i && addr_i == 8'h69 |=> left_mix_o[17:11] == {$past(wdata_i[7]), $past(wdata_i[5:0])}; endproperty
  a_rte: assert property (p_rte) else $error("routing wrong");
  property p_lvl; wr_i && addr_i == 8'h6b |=> left_mix_o[10:2] == $past(wdata_i[8:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("mute or level wrong");
  property p_dac; wr_i && addr_i == 8'h6d |=> left_mix_o[1:0] == $past(wdata_i[7:6]); endproperty
  a_dac: assert property (p_dac) else $error("dac level wrong");
  property p_rst; $rose(rst_n_i) |-> enables_o == 12'h000 && left_mix_o == 18'h0_04fc; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold; !wr_i || addr_i == 8'h00 |=> $stable(enables_o) && $stable(left_mix_o); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without write");
  property p_rd; rd_i && addr_i == 8'h6b |=> rdata_o == {7'h00, $past(left_mix_o[10:2])}; endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_rdz; !rd_i |=> rdata_o == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data not cleared");
endmodule : opse_ctrl_sva
bind opse_ctrl opse_ctrl_sva u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enables_o(enables_o),
  .left_mix_o(left_mix_o));
`default_nettype wire

/* bench/opse_ctrl_tb_top.sv */
// Purpose: Register-level test of the output path control bank
// Assumes: Read data stands in the cycle after the read strobe
// Notes: Run twice, the second pass after a reset in mid-run
`timescale 1ns/1ps
`default_nettype none
module opse_ctrl_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  opse_pkg::opse_enables_t enables_o;
  opse_pkg::opse_left_mix_t left_mix_o;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] ra [7] = '{8'h1a, 8'h31, 8'h45, 8'h63, 8'h69, 8'h6b, 8'h6d};
  logic [15:0] rm [7] = '{16'h0078, 16'h00c0, 16'h0011, 16'h000f, 16'h00bf, 16'h01ff, 16'h00c0};
  logic [15:0] rr [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h013f, 16'h0000};
  opse_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enables_o(enables_o), .left_mix_o(left_mix_o));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_en(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_en
  task automatic chk_mix(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mix
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk_rd(rdata_o, exp);
  endtask : rd
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Second pass resets with every bit set, so reset must clear live state
  initial begin
    for (int p = 0; p < 2; p++) begin
      if (p > 0) begin
        @(posedge ref_clk_i);
      end
      rst_n_i <= 1'b0;
      repeat (16) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      foreach (ra[i]) rd(ra[i], rr[i]);
      chk_en(enables_o, 12'h000);
      chk_mix(left_mix_o, 18'h0_04fc);
      // Reference and bias live outside this bank and are taken as already on
      wr(8'h1a, 16'h0050);
      wr(8'h31, 16'h0080);
      wr(8'h63, 16'h000a);
      // Input stage goes last, after its mixer and gain stage
      wr(8'h45, 16'h0010);
      chk_en(enables_o, 12'ha6a);
      wr(8'h69, 16'h0081);
      wr(8'h6b, 16'h00a9);
      wr(8'h6d, 16'h0040);
      chk_mix(left_mix_o, 18'h2_0aa5);
      foreach (ra[i]) begin
        for (int b = 0; b < 16; b++) begin
          wr(ra[i], 16'h0001 << b);
          rd(ra[i], (16'h0001 << b) & rm[i]);
        end
        wr(ra[i], 16'hffff);
      end
      chk_en(enables_o, 12'hfff);
      chk_mix(left_mix_o, 18'h3_ffff);
      wr(8'h00, 16'h0000);
      wr(8'h6a, 16'h0000);
      rd(8'h00, 16'h0000);
      rd(8'h6a, 16'h0000);
      foreach (ra[i]) rd(ra[i], rm[i]);
    end
    final_report();
  end
  initial begin
    #900000;
    fails++;
    final_report();
  end
endmodule : opse_ctrl_tb_top
`default_nettype wire
